// ==== rtl/cmbm_core.sv ====
/*
  Message storage of a CAN controller: two-stage receive FIFO, three
  ranked transmit buffers with abort, APB register access.
  Assumes a protocol engine that streams received bytes, flags end of
  frame, filter result and transmit outcome, and reads transmit bytes.
*/
// Chosen here: the address map and register access over APB.
//
// Contract
// RULE_01: Receive FIFO has two entries; only the front entry is CPU visible.
// RULE_02: Each receive buffer holds thirteen bytes of control, identifier, data.
// RULE_03: Receive-full flag marks an accepted good message in the front buffer.
// RULE_04: Incoming bytes always land in the back buffer, accepted or not. Here they are blocked while it holds a kept message.
// RULE_05: With receive-full clear, accepted message moves front, flag and interrupt.
// RULE_06: Software reads the front buffer then clears receive-full.
// RULE_07: Back buffer takes a new frame right after the inter-frame space.
// RULE_08: Own transmitted frame stays in back buffer, no interrupt, no acknowledge.
// RULE_09: Loop-back treats own frames like any other incoming frame.
// RULE_10: After lost arbitration the winning frame is received normally.
// RULE_11: Third accepted message is dropped and overrun raised when enabled.
// RULE_12: With both buffers full transmit works, every incoming frame dropped.
// RULE_13: Three thirteen-byte transmit buffers, each with an 8-bit rank.
// RULE_14: Software fills an empty buffer, then clears its empty flag.
// RULE_15: Successful send sets the empty flag and transmit interrupt.
// RULE_16: Among ready buffers the smallest rank value is sent first.
// RULE_17: Selection is redone at every arbitration attempt, retries included.
// RULE_18: Abort request frees a buffer not on the bus, sets acknowledge.
// RULE_19: Abort acknowledge reads one when aborted, zero when sent.
// RULE_20: Transmit pin is zero for dominant, one for recessive.
// RULE_21: Flags clear by writing one; a live condition keeps them set.
// RULE_22: Receive interrupt rises as soon as end of frame is taken.
// RULE_23: Transmit pin stays recessive in any low-power mode.
// RULE_24: Front buffer stays unchanged while receive-full is set.
`timescale 1ns/1ps
`default_nettype none
module cmbm_core
  import cmbm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_receive_pin,
  output logic can_transmit_pin,
  output logic eng_rx_bit,
  input wire logic eng_tx_dominant,
  input wire logic eng_rx_we,
  input wire logic [3:0] eng_rx_idx,
  input wire logic [7:0] eng_rx_byte,
  input wire logic eng_rx_done,
  input wire logic eng_rx_accept,
  output logic eng_ack_enable,
  output logic eng_tx_pending,
  input wire logic eng_arb_start,
  input wire logic eng_arb_lost,
  input wire logic eng_tx_error,
  input wire logic eng_tx_done,
  input wire logic [3:0] eng_tx_idx,
  output logic [7:0] eng_tx_byte,
  output logic irq_receive,
  output logic irq_transmit,
  output logic irq_error
);
  import cmbm_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic receive_full_flag;
    logic ovr;
    logic back_full;
    logic [2:0] transmit_empty_flag;
    logic [2:0] abak;
    logic [2:0] abrq;
    logic [12:0][7:0] back;
    logic [12:0][7:0] front;
    logic [2:0][12:0][7:0] txb;
    logic [2:0][7:0] rank;
    cmbm_txst_t st;
    logic [1:0] cur;
    logic [31:0] rdata;
    logic [7:0] tx_byte;
    logic tx_pin;
  } cmbm_state_t;

  cmbm_state_t s;
  cmbm_state_t next_s;

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  logic [3:0] word;
  logic [2:0] blk;
  logic [1:0] tbuf;
  logic hit_rx;
  logic hit_tx;
  logic hit;
  logic [31:0] rmux;
  logic [2:0] ready;
  logic [1:0] pick;
  logic [7:0] min_rank;
  logic tx_own;
  logic done_ok;
  logic wr;

  assign word = paddr[5:2];
  assign blk = paddr[8:6];
  assign tbuf = 2'(blk - TX_WIN_FIRST);
  assign hit_rx = (paddr[11:6] == RX_WIN_BLOCK) && (word <= LAST_BYTE); // [RULE_01]
  assign hit_tx = (paddr[11:9] == 3'h0) && (blk >= TX_WIN_FIRST) && (blk <= TX_WIN_LAST)
                  && (word <= RANK_WORD);
  assign wr = psel && penable && pwrite;
  assign tx_own = (s.st == CMBM_TX_SEND);
  // A frame counts as foreign unless it is our own one outside loop-back.
  assign done_ok = eng_rx_done && eng_rx_accept && (!tx_own || s.ctrl[CTRL_LOOP]); // [RULE_08] [RULE_09] [RULE_10]
  assign ready = ~s.transmit_empty_flag & ~s.abrq;

  always_comb
  begin
    hit = 1'b1;
    rmux = 32'h0000_0000;
    if (hit_rx)
    begin
      rmux = {24'h00_0000, s.front[word]};
    end
    else if (hit_tx)
    begin
      rmux = {24'h00_0000, (word == RANK_WORD) ? s.rank[tbuf] : s.txb[tbuf][word]};
    end
    else
    begin
      unique case (paddr)
        ADDR_CTRL: rmux = {24'h00_0000, s.ctrl};
        ADDR_RFLG: rmux = {30'h0000_0000, s.ovr, s.receive_full_flag};
        ADDR_TFLG: rmux = {25'h000_0000, s.abak, 1'b0, s.transmit_empty_flag};
        ADDR_TCTL: rmux = {29'h0000_0000, s.abrq};
        default: hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Local rank selection
  // ----------------------------------------------------------------
  always_comb
  begin
    pick = 2'h0;
    min_rank = 8'hFF;
    for (int i = NUM_TX - 1; i >= 0; i--)
    begin
      if (ready[i] && (s.rank[i] <= min_rank))
      begin
        pick = 2'(i);
        min_rank = s.rank[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (psel && !penable)
    begin
      next_s.rdata = rmux;
    end
    if (wr && hit_tx)
    begin
      if (word == RANK_WORD)
      begin
        next_s.rank[tbuf] = pwdata[7:0]; // [RULE_13]
      end
      else
      begin
        next_s.txb[tbuf][word] = pwdata[7:0]; // [RULE_13] [RULE_14]
      end
    end
    else if (wr && !hit_rx)
    begin
      unique case (paddr)
        ADDR_CTRL: next_s.ctrl = pwdata[7:0];
        ADDR_RFLG:
        begin
          if (pwdata[RFLG_RXF])
          begin
            next_s.receive_full_flag = 1'b0; // [RULE_21]
          end
          if (pwdata[RFLG_OVR])
          begin
            next_s.ovr = 1'b0; // [RULE_21]
          end
        end
        ADDR_TFLG:
        begin
          next_s.transmit_empty_flag = s.transmit_empty_flag & ~pwdata[2:0]; // [RULE_14] [RULE_21]
          next_s.abak = s.abak & ~pwdata[2:0];
        end
        ADDR_TCTL: next_s.abrq = s.abrq | (pwdata[2:0] & ~s.transmit_empty_flag);
        default: next_s.ctrl = s.ctrl;
      endcase
    end

    // Back buffer is written on every frame; blocked only while it holds a kept message.
    if (eng_rx_we && !s.back_full && (eng_rx_idx <= LAST_BYTE))
    begin
      next_s.back[eng_rx_idx] = eng_rx_byte; // [RULE_02] [RULE_04] [RULE_07] [RULE_12]
    end
    if (!s.receive_full_flag && s.back_full)
    begin
      next_s.front = s.back; // [RULE_01]
      next_s.receive_full_flag = 1'b1;
      next_s.back_full = 1'b0;
    end
    // Hardware events come last so a set beats a clear in the same cycle.
    if (done_ok)
    begin
      if (!s.receive_full_flag && !s.back_full)
      begin
        next_s.front = s.back; // [RULE_05] [RULE_22] [RULE_24]
        next_s.receive_full_flag = 1'b1; // [RULE_03]
      end
      else if (!s.back_full)
      begin
        next_s.back_full = 1'b1; // [RULE_01]
      end
      else
      begin
        next_s.ovr = 1'b1; // [RULE_11] [RULE_12]
      end
    end

    unique case (s.st)
      CMBM_TX_IDLE:
      begin
        if (eng_arb_start && (|ready))
        begin
          next_s.st = CMBM_TX_SEND; // [RULE_16] [RULE_17]
          next_s.cur = pick;
        end
      end
      CMBM_TX_SEND:
      begin
        if (eng_tx_done)
        begin
          next_s.transmit_empty_flag[s.cur] = 1'b1; // [RULE_15]
          next_s.abak[s.cur] = 1'b0; // [RULE_19]
          next_s.abrq[s.cur] = 1'b0;
          next_s.st = CMBM_TX_IDLE;
        end
        else if (eng_arb_lost || eng_tx_error)
        begin
          next_s.st = CMBM_TX_IDLE; // [RULE_10] [RULE_17]
        end
      end
    endcase

    for (int i = 0; i < NUM_TX; i++)
    begin
      if (s.abrq[i] && s.transmit_empty_flag[i])
      begin
        next_s.abrq[i] = 1'b0;
      end
      else if (s.abrq[i] && !(tx_own && (s.cur == 2'(i))))
      begin
        next_s.transmit_empty_flag[i] = 1'b1; // [RULE_18]
        next_s.abak[i] = 1'b1; // [RULE_19]
        next_s.abrq[i] = 1'b0;
      end
    end

    next_s.tx_pin = s.ctrl[CTRL_LOWPWR] | ~eng_tx_dominant; // [RULE_20] [RULE_23]
    next_s.tx_byte = (eng_tx_idx <= LAST_BYTE) ? s.txb[s.cur][eng_tx_idx] : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.transmit_empty_flag <= TXE_RST;
      s.rank <= {NUM_TX{RANK_RST}};
      s.st <= CMBM_TX_IDLE;
      s.tx_pin <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign can_transmit_pin = s.tx_pin;
  assign eng_rx_bit = s.ctrl[CTRL_LOOP] ? s.tx_pin : can_receive_pin; // [RULE_09]
  assign eng_ack_enable = !(tx_own && !s.ctrl[CTRL_LOOP]); // [RULE_08]
  assign eng_tx_pending = |ready;
  assign eng_tx_byte = s.tx_byte;
  assign irq_receive = s.receive_full_flag && s.ctrl[CTRL_RXFIE]; // [RULE_05]
  assign irq_transmit = |(s.transmit_empty_flag & s.ctrl[CTRL_TXEIE +: 3]); // [RULE_15] [RULE_18]
  assign irq_error = s.ovr && s.ctrl[CTRL_OVRIE]; // [RULE_11]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take_free;
    done_ok && !s.receive_full_flag && !s.back_full;
  endsequence
  sequence s_take_full;
    done_ok && s.receive_full_flag && s.back_full;
  endsequence

  AST_RXF_SET: assert property (s_take_free |=> s.receive_full_flag && (s.front == $past(s.back))) // [RULE_05]
    else $error("Accepted frame did not reach the front buffer.");
  AST_FRONT_HOLD: assert property (s.receive_full_flag |=> $stable(s.front)) // [RULE_24]
    else $error("Front buffer changed while full.");
  AST_OWN_FRAME: assert property (eng_rx_done && tx_own && !s.ctrl[CTRL_LOOP] && !s.receive_full_flag
    && !s.back_full |=> !s.receive_full_flag && !s.back_full) // [RULE_08]
    else $error("Own frame was stored as received.");
  AST_OVERRUN: assert property (s_take_full |=> s.ovr && s.back_full && $stable(s.back)) // [RULE_11]
    else $error("Overrun not flagged or back buffer altered.");
  AST_TX_DONE: assert property (tx_own && eng_tx_done |=> s.transmit_empty_flag[$past(s.cur)]
    && !s.abak[$past(s.cur)] && (s.st == CMBM_TX_IDLE)) // [RULE_15]
    else $error("Sent buffer not marked empty.");
  AST_RANK: assert property (!tx_own && eng_arb_start && (|ready)
    |=> tx_own && (s.rank[s.cur] == $past(min_rank))) // [RULE_16]
    else $error("Buffer with lowest rank not chosen.");
  AST_ABORT: assert property (s.abrq[0] && !s.transmit_empty_flag[0] && !(tx_own && s.cur == 2'h0)
    |=> s.transmit_empty_flag[0] && s.abak[0] ##1 s.transmit_empty_flag[0]) // [RULE_18]
    else $error("Abort request was not granted.");
  AST_LOWPWR: assert property (s.ctrl[CTRL_LOWPWR] [*2] |-> can_transmit_pin) // [RULE_23]
    else $error("Transmit pin not recessive in low power.");
  AST_PIN_LEVEL: assert property (!s.ctrl[CTRL_LOWPWR] && eng_tx_dominant
    |=> !can_transmit_pin) // [RULE_20]
    else $error("Dominant level not driven as zero.");
  AST_RXF_CLEAR: assert property (wr && (paddr == ADDR_RFLG) && pwdata[RFLG_RXF]
    && !done_ok && !s.back_full |=> !s.receive_full_flag) // [RULE_21]
    else $error("Receive-full flag did not clear.");
endmodule // cmbm_core
`default_nettype wire

// ==== rtl/cmbm_pkg.sv ====
/*
  Constants and types of the CAN message buffer manager.
  Assumes a 32-bit APB register bus and one 100 MHz clock.
*/
`default_nettype none
package cmbm_pkg;
  // ----------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------
  localparam int unsigned BUF_BYTES = 13;
  localparam int unsigned NUM_TX = 3;
  localparam logic [3:0] LAST_BYTE = 4'hC;
  localparam logic [3:0] RANK_WORD = 4'hD;

  // ----------------------------------------------------------------
  // Register map (byte addresses, and 64-byte window block numbers)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_RFLG = 12'h004;
  localparam logic [11:0] ADDR_TFLG = 12'h008;
  localparam logic [11:0] ADDR_TCTL = 12'h00C;
  localparam logic [5:0] RX_WIN_BLOCK = 6'h01;
  localparam logic [2:0] TX_WIN_FIRST = 3'h2;
  localparam logic [2:0] TX_WIN_LAST = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_LOOP = 0;
  localparam int unsigned CTRL_LOWPWR = 1;
  localparam int unsigned CTRL_RXFIE = 2;
  localparam int unsigned CTRL_OVRIE = 3;
  localparam int unsigned CTRL_TXEIE = 4;
  localparam int unsigned RFLG_RXF = 0;
  localparam int unsigned RFLG_OVR = 1;
  localparam int unsigned TFLG_ABAK = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] TXE_RST = 3'h7;
  localparam logic [7:0] RANK_RST = 8'h00;

  typedef enum logic {CMBM_TX_IDLE, CMBM_TX_SEND} cmbm_txst_t;
endpackage
`default_nettype wire

// ==== verif/cmbm_engine_model.sv ====
/*
  Protocol engine stand-in that streams frames and transmit outcomes.
  Assumes tasks are called by the bench, with pclk running.
*/
`timescale 1ns/1ps
`default_nettype none
module cmbm_engine_model (
  input wire logic pclk,
  output logic eng_rx_we,
  output logic [3:0] eng_rx_idx,
  output logic [7:0] eng_rx_byte,
  output logic eng_rx_done,
  output logic eng_rx_accept,
  output logic eng_arb_start,
  output logic eng_arb_lost,
  output logic eng_tx_error,
  output logic eng_tx_done
);
  initial {eng_rx_we, eng_rx_idx, eng_rx_byte, eng_rx_done, eng_rx_accept} = '0;
  initial {eng_arb_start, eng_arb_lost, eng_tx_error, eng_tx_done} = '0;

  // Released data lines show the inverse so stale values are never trusted.
  task automatic frame(input logic [7:0] b [13], input logic a);
    for (int i = 0; i < 13; i++)
    begin
      @(posedge pclk);
      eng_rx_we <= 1'b1;
      eng_rx_idx <= 4'(i);
      eng_rx_byte <= b[i];
    end
    @(posedge pclk);
    eng_rx_we <= 1'b0;
    eng_rx_byte <= ~b[12];
    eng_rx_done <= 1'b1;
    eng_rx_accept <= a;
    @(posedge pclk);
    eng_rx_done <= 1'b0;
    eng_rx_accept <= ~a;
  endtask

  task automatic evt(input logic [3:0] m);
    @(posedge pclk);
    {eng_arb_start, eng_arb_lost, eng_tx_error, eng_tx_done} <= m;
    @(posedge pclk);
    {eng_arb_start, eng_arb_lost, eng_tx_error, eng_tx_done} <= 4'h0;
  endtask
endmodule // cmbm_engine_model
`default_nettype wire

// ==== verif/test_can_message_buffer_manager.sv ====
/*
  Self-checking bench of the CAN message buffer manager.
  Assumes the engine model beside it and zero-wait APB answers.
*/
`timescale 1ns/1ps
`default_nettype none
module test_can_message_buffer_manager;
  import cmbm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, rbit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, can_transmit_pin, eng_rx_bit, eng_ack_enable, eng_tx_pending;
  logic can_receive_pin, eng_tx_dominant;
  logic [3:0] eng_tx_idx;
  logic eng_rx_we, eng_rx_done, eng_rx_accept, eng_arb_start, eng_arb_lost, eng_tx_error;
  logic eng_tx_done, irq_receive, irq_transmit, irq_error;
  logic [3:0] eng_rx_idx;
  logic [7:0] eng_rx_byte, eng_tx_byte;
  logic [7:0] f1 [13], f2 [13], f3 [13], tb [3];
  logic [32:0] exq [$];
  int fails = 0, check_count = 0;

  cmbm_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .can_receive_pin, .can_transmit_pin, .eng_rx_bit, .eng_tx_dominant, .eng_rx_we,
    .eng_rx_idx, .eng_rx_byte, .eng_rx_done, .eng_rx_accept, .eng_ack_enable, .eng_tx_pending,
    .eng_arb_start, .eng_arb_lost, .eng_tx_error, .eng_tx_done, .eng_tx_idx, .eng_tx_byte,
    .irq_receive, .irq_transmit, .irq_error);
  cmbm_engine_model eng (.pclk, .eng_rx_we, .eng_rx_idx, .eng_rx_byte, .eng_rx_done,
    .eng_rx_accept, .eng_arb_start, .eng_arb_lost, .eng_tx_error, .eng_tx_done);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // A read notes {pslverr, prdata} expected; the watcher below compares it.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 21; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
      if (n == 20)
      begin
        fails++;
        report_and_stop();
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask

  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
      check("apb read", {pslverr, prdata}, exq.pop_front());

  task automatic rdbuf(input logic [7:0] b [13]);
    for (int i = 0; i < 13; i++)
      apb(1'b0, 12'h040 + 12'(4 * i), 32'h0, 33'(b[i]));
  endtask

  task automatic settle();
    @(posedge pclk);
    #1;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    can_receive_pin <= 1'b1;
    eng_tx_dominant <= 1'b0;
    eng_tx_idx <= 4'h0;
    void'($urandom(32'h0E1E));
    for (int i = 0; i < 13; i++)
    begin
      f1[i] = 8'($urandom);
      f2[i] = 8'($urandom);
      f3[i] = 8'($urandom);
    end
    for (int n = 0; n < 3; n++)
      tb[n] = 8'($urandom);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_TFLG, 32'h0, 33'h7);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h0);
    apb(1'b0, 12'hFF0, 32'h0, 33'h100000000);
    apb(1'b1, ADDR_CTRL, 32'h7C, 33'h0);
    eng.frame(f1, 1'b1);
    #1;
    check("irq rx", 33'(irq_receive), 33'h1);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h1);
    rdbuf(f1);
    eng.frame(f2, 1'b0);
    apb(1'b0, 12'h040, 32'h0, 33'(f1[0]));
    eng.frame(f2, 1'b1);
    eng.frame(f3, 1'b1);
    #1;
    check("irq err", 33'(irq_error), 33'h1);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h3);
    apb(1'b1, ADDR_RFLG, 32'h3, 33'h0);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h1);
    rdbuf(f2);
    apb(1'b1, ADDR_RFLG, 32'h1, 33'h0);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h0);
    for (int n = 0; n < 3; n++)
    begin
      apb(1'b1, 12'h080 + 12'(64 * n), 32'(tb[n]), 33'h0);
      apb(1'b1, 12'h080 + 12'(64 * n) + {6'h0, RANK_WORD, 2'b00}, 32'h30 - 32'(16 * n), 33'h0);
    end
    apb(1'b1, ADDR_TFLG, 32'h7, 33'h0);
    #1;
    check("pending", 33'(eng_tx_pending), 33'h1);
    eng.evt(4'h8);
    settle();
    check("tx byte", 33'(eng_tx_byte), 33'(tb[2]));
    check("ack en", 33'(eng_ack_enable), 33'h0);
    // Byte indices beyond the last buffer byte must read as zero.
    eng_tx_idx <= 4'hD + 4'($urandom_range(2));
    settle();
    check("tx byte hi", 33'(eng_tx_byte), 33'h0);
    eng_tx_idx <= 4'h0;
    apb(1'b1, 12'h100 + {6'h0, RANK_WORD, 2'b00}, 32'h30, 33'h0);
    eng.evt(4'h2);
    eng.evt(4'h8);
    settle();
    check("retry byte", 33'(eng_tx_byte), 33'(tb[1]));
    eng.evt(4'h1);
    settle();
    check("irq tx", 33'(irq_transmit), 33'h1);
    apb(1'b0, ADDR_TFLG, 32'h0, 33'h2);
    apb(1'b1, ADDR_TCTL, 32'h1, 33'h0);
    apb(1'b0, ADDR_TFLG, 32'h0, 33'h13);
    eng.evt(4'h8);
    apb(1'b1, ADDR_TCTL, 32'h4, 33'h0);
    eng.evt(4'h1);
    apb(1'b0, ADDR_TFLG, 32'h0, 33'h17);
    apb(1'b1, ADDR_TFLG, 32'h1, 33'h0);
    eng.evt(4'h8);
    eng.frame(f1, 1'b1);
    eng.evt(4'h1);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h7D, 33'h0);
    // In loop-back the engine must hear the recessive transmit pin, not the bus pin.
    can_receive_pin <= 1'b0;
    settle();
    check("loop bit", 33'(eng_rx_bit), 33'h1);
    apb(1'b1, ADDR_TFLG, 32'h1, 33'h0);
    eng.evt(4'h8);
    eng.frame(f3, 1'b1);
    eng.evt(4'h1);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h1);
    apb(1'b0, 12'h040, 32'h0, 33'(f3[0]));
    apb(1'b1, ADDR_RFLG, 32'h1, 33'h0);
    apb(1'b1, ADDR_CTRL, 32'h7C, 33'h0);
    apb(1'b1, ADDR_TFLG, 32'h1, 33'h0);
    eng.evt(4'h8);
    eng.evt(4'h4);
    eng.frame(f2, 1'b1);
    apb(1'b0, ADDR_RFLG, 32'h0, 33'h1);
    rbit = 1'($urandom);
    eng_tx_dominant <= 1'b1;
    can_receive_pin <= rbit;
    @(posedge pclk);
    settle();
    check("tx pin", 33'(can_transmit_pin), 33'h0);
    check("rx bit", 33'(eng_rx_bit), 33'(rbit));
    apb(1'b1, ADDR_CTRL, 32'h7E, 33'h0);
    @(posedge pclk);
    settle();
    check("tx pin lp", 33'(can_transmit_pin), 33'h1);
    report_and_stop();
  end
endmodule // test_can_message_buffer_manager
`default_nettype wire
